// >>> hw/ccr_pkg.sv
`default_nettype none
package ccr_pkg;

  localparam logic [15:0] PERIPH_LO     = 16'hFF00;
  localparam logic [15:0] PERIPH_HI     = 16'hFFFF;
  localparam logic [15:0] GPR_LO        = 16'hFEE0;
  localparam logic [15:0] GPR_HI        = 16'hFEFF;
  localparam logic [15:0] RESET_VEC_LO  = 16'h0000;
  localparam logic [15:0] RESET_VEC_HI  = 16'h0001;
  localparam logic [7:0]  FLAGS_RESET   = 8'h02;
  localparam logic [7:0]  UNMAPPED_READ = 8'h00;

  localparam int FLAG_GATE  = 7;
  localparam int FLAG_ZERO  = 6;
  localparam int FLAG_BSH   = 5;
  localparam int FLAG_HALF  = 4;
  localparam int FLAG_BSL   = 3;
  localparam int FLAG_SVC   = 1;
  localparam int FLAG_CARRY = 0;

  localparam logic [5:0] REG_PC     = 6'h00;
  localparam logic [5:0] REG_FLAGS  = 6'h01;
  localparam logic [5:0] REG_SP     = 6'h02;
  localparam logic [5:0] REG_CMD    = 6'h03;
  localparam logic [5:0] REG_RESULT = 6'h04;
  localparam logic [5:0] REG_IRQ    = 6'h05;
  localparam logic [5:0] REG_STKDAT = 6'h06;
  localparam logic [5:0] REG_PAIR   = 6'h07;
  localparam logic [5:0] REG_GPR    = 6'h20;

  typedef enum logic [3:0] {
    CMD_NONE, CMD_ADVANCE, CMD_BRANCH, CMD_MASK_ALL, CMD_UNMASK_ALL,
    CMD_BANK_SWITCH, CMD_PUSH_FLAGS, CMD_POP_FLAGS, CMD_PUSH_BYTE,
    CMD_POP_BYTE, CMD_INTERRUPT, CMD_INT_RETURN, CMD_BRK_RETURN,
    CMD_ALU_ADD, CMD_ALU_SUB, CMD_ROTATE
  } ccr_cmd_t;

  typedef struct packed {
    logic [7:0]  bank;
    logic [15:0] value;
  } ccr_pair_t;

endpackage : ccr_pkg
`default_nettype wire

// >>> hw/ccr_core.sv
`timescale 1ns/1ns
`default_nettype none
module ccr_core #(
  parameter int BANKS = 4
) (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [15:0] mem_addr,
  input  wire logic        mem_we,
  input  wire logic [7:0]  mem_wdata,
  output logic      [7:0]  mem_rdata,
  output logic             mem_hit,
  input  wire logic        irq_req,
  input  wire logic        irq_low_level,
  input  wire logic        irq_unmasked,
  output logic             irq_accept,
  output logic      [15:0] stack_addr,
  output logic      [15:0] program_counter
);

  typedef enum logic [2:0] {
    RET_IDLE,
    RET_LOW,
    RET_HIGH,
    RET_FLAGS,
    RET_WAIT,
    RET_STACK,
    RET_LOAD
  } ccr_ret_state_t;

  logic [7:0]        gpr_q [BANKS*8];
  logic [7:0]        processor_flags_word;
  logic [15:0]       stack_top_pointer;
  logic [7:0]        vec_lo_q;
  logic [15:0]       ret_q;
  ccr_ret_state_t    ret_state_q;
  logic [7:0]        result_q;
  logic [7:0]        stk_dat_q;
  logic [15:0]       pair_q;
  logic [15:0]       arg_q;
  logic              vec_phase_q;
  logic              ack_q;
  logic              wr;
  logic              rd;
  logic              cmd_wr;
  logic              ret_start;
  ccr_pkg::ccr_cmd_t cmd;
  logic [8:0]        alu;
  logic [4:0]        half;
  logic [1:0]        bank;

  function automatic logic [4:0] gpr_index(input logic [15:0] a);
    // Bank 0 holds the top eight bytes, higher banks sit lower.
    gpr_index = {~a[4:3], a[2:0]};
  endfunction : gpr_index

  function automatic logic in_range(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
    in_range = (a >= lo) && (a <= hi);
  endfunction : in_range

  function automatic logic word_at(input logic [7:0] adr,
                                   input logic [5:0] word);
    word_at = adr[7:2] == word;
  endfunction : word_at

  assign wr     = wb_cyc_i && wb_stb_i && wb_we_i && !ack_q && wb_sel_i[0];
  assign rd     = wb_cyc_i && wb_stb_i && !ack_q;
  assign cmd_wr = wr && word_at(wb_adr_i, ccr_pkg::REG_CMD);
  assign cmd    = ccr_pkg::ccr_cmd_t'(wb_dat_i[3:0]);
  assign ret_start = cmd_wr && (cmd == ccr_pkg::CMD_INT_RETURN
                     || cmd == ccr_pkg::CMD_BRK_RETURN);
  assign bank   = {processor_flags_word[ccr_pkg::FLAG_BSH],
                   processor_flags_word[ccr_pkg::FLAG_BSL]};

  // Arithmetic used by add and subtract commands on the operand word.
  always_comb
  begin
    if (cmd == ccr_pkg::CMD_ALU_SUB)
    begin
      alu  = {1'b0, wb_dat_i[15:8]} - {1'b0, wb_dat_i[23:16]};
      half = {1'b0, wb_dat_i[11:8]} - {1'b0, wb_dat_i[19:16]};
    end
    else
    begin
      alu  = {1'b0, wb_dat_i[15:8]} + {1'b0, wb_dat_i[23:16]};
      half = {1'b0, wb_dat_i[11:8]} + {1'b0, wb_dat_i[19:16]};
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ack_q <= 1'b0;
    else
      ack_q <= rd;
  end
  assign wb_ack_o = ack_q;

  // Reset vector fetch: low byte from even address, then odd.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      vec_phase_q     <= 1'b0;
      vec_lo_q        <= 8'h00;
      program_counter <= 16'h0000;
    end
    else if (wr && wb_adr_i[7:2] == ccr_pkg::REG_PC)
      program_counter <= wb_dat_i[15:0];
    else if (cmd_wr && cmd == ccr_pkg::CMD_ADVANCE)
      program_counter <= program_counter + {13'h0000, wb_dat_i[6:4]};
    else if (cmd_wr && cmd == ccr_pkg::CMD_BRANCH)
      program_counter <= wb_dat_i[31:16];
    else if (cmd_wr && cmd == ccr_pkg::CMD_INTERRUPT && irq_accept)
      program_counter <= wb_dat_i[31:16];
    else if (ret_state_q == RET_LOAD)
      program_counter <= ret_q;
    else if (mem_we && mem_addr == ccr_pkg::RESET_VEC_LO)
    begin
      vec_lo_q    <= mem_wdata;
      vec_phase_q <= 1'b1;
    end
    else if (mem_we && mem_addr == ccr_pkg::RESET_VEC_HI && vec_phase_q)
    begin
      program_counter <= {mem_wdata, vec_lo_q};
      vec_phase_q     <= 1'b0;
    end
  end

  // Acceptance: gate, request, service level and source mask.
  assign irq_accept = processor_flags_word[ccr_pkg::FLAG_GATE] && irq_req
    && irq_unmasked
    && (processor_flags_word[ccr_pkg::FLAG_SVC] || !irq_low_level);

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      processor_flags_word <= ccr_pkg::FLAGS_RESET;
    else if (wr && wb_adr_i[7:2] == ccr_pkg::REG_FLAGS)
      processor_flags_word <= wb_dat_i[7:0];
    else if (cmd_wr)
    begin
      case (cmd)
        ccr_pkg::CMD_MASK_ALL:
          processor_flags_word[ccr_pkg::FLAG_GATE] <= 1'b0;
        ccr_pkg::CMD_UNMASK_ALL:
          processor_flags_word[ccr_pkg::FLAG_GATE] <= 1'b1;
        ccr_pkg::CMD_INTERRUPT:
          if (irq_accept)
            processor_flags_word[ccr_pkg::FLAG_GATE] <= 1'b0;
        ccr_pkg::CMD_BANK_SWITCH:
        begin
          processor_flags_word[ccr_pkg::FLAG_BSL] <= wb_dat_i[4];
          processor_flags_word[ccr_pkg::FLAG_BSH] <= wb_dat_i[5];
        end
        ccr_pkg::CMD_ALU_ADD, ccr_pkg::CMD_ALU_SUB:
        begin
          processor_flags_word[ccr_pkg::FLAG_ZERO]  <= alu[7:0] == 8'h00;
          processor_flags_word[ccr_pkg::FLAG_HALF]  <= half[4];
          processor_flags_word[ccr_pkg::FLAG_CARRY] <= alu[8];
        end
        ccr_pkg::CMD_ROTATE:
          processor_flags_word[ccr_pkg::FLAG_CARRY] <= wb_dat_i[15];
        ccr_pkg::CMD_POP_FLAGS:
          processor_flags_word <= stk_dat_q;
        default:
          processor_flags_word <= processor_flags_word;
      endcase
    end
    else if (ret_state_q == RET_LOAD)
      processor_flags_word <= stk_dat_q;
  end

  // Stack pointer: one byte per push or pop, three per interrupt.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      stack_top_pointer <= 16'h0000;
    else if (wr && word_at(wb_adr_i, ccr_pkg::REG_SP))
      stack_top_pointer <= wb_dat_i[15:0];
    else if (cmd_wr)
    begin
      case (cmd)
        ccr_pkg::CMD_PUSH_BYTE, ccr_pkg::CMD_PUSH_FLAGS:
          stack_top_pointer <= stack_top_pointer - 16'h0001;
        ccr_pkg::CMD_POP_BYTE, ccr_pkg::CMD_POP_FLAGS:
          stack_top_pointer <= stack_top_pointer + 16'h0001;
        ccr_pkg::CMD_INTERRUPT:
          if (irq_accept)
            stack_top_pointer <= stack_top_pointer - 16'h0003;
        default:
          stack_top_pointer <= stack_top_pointer;
      endcase
    end
    else if (ret_state_q == RET_STACK)
      stack_top_pointer <= arg_q + 16'h0003;
  end
  assign stack_addr = stack_top_pointer;

  // Operation result of the add, subtract and rotate commands.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      result_q <= 8'h00;
    else if (cmd_wr && (cmd == ccr_pkg::CMD_ALU_ADD
             || cmd == ccr_pkg::CMD_ALU_SUB))
      result_q <= alu[7:0];
    else if (cmd_wr && cmd == ccr_pkg::CMD_ROTATE)
      result_q <= {wb_dat_i[14:8], wb_dat_i[15]};
  end

  // Return sequence steps once a cycle through the three bytes.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      ret_state_q <= RET_IDLE;
    else
    begin
      case (ret_state_q)
        RET_IDLE:
          if (ret_start)
            ret_state_q <= RET_LOW;
        RET_LOW:
          ret_state_q <= RET_HIGH;
        RET_HIGH:
          ret_state_q <= RET_FLAGS;
        RET_FLAGS:
          ret_state_q <= RET_WAIT;
        RET_WAIT:
          ret_state_q <= RET_STACK;
        RET_STACK:
          ret_state_q <= RET_LOAD;
        RET_LOAD:
          ret_state_q <= RET_IDLE;
        default:
          ret_state_q <= RET_IDLE;
      endcase
    end
  end

  // Return data capture: low byte, high byte, then saved flags.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ret_q     <= 16'h0000;
      stk_dat_q <= 8'h00;
      arg_q     <= 16'h0000;
    end
    else if (ret_start)
      arg_q <= stack_top_pointer;
    else if (ret_state_q == RET_LOW)
      ret_q[7:0] <= mem_rdata;
    else if (ret_state_q == RET_HIGH)
      ret_q[15:8] <= mem_rdata;
    else if (ret_state_q == RET_FLAGS)
      stk_dat_q <= mem_rdata;
    else if (wr && word_at(wb_adr_i, ccr_pkg::REG_STKDAT))
      stk_dat_q <= wb_dat_i[7:0];
  end

  // Register banks live in data memory at FEE0H to FEFFH.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < BANKS*8; i++)
        gpr_q[i] <= 8'h00;
    end
    else if (mem_we && in_range(mem_addr, ccr_pkg::GPR_LO, ccr_pkg::GPR_HI))
      gpr_q[gpr_index(mem_addr)] <= mem_wdata;
    else if (wr && wb_adr_i[7:5] == ccr_pkg::REG_GPR[5:3])
      gpr_q[{bank, wb_adr_i[4:2]}] <= wb_dat_i[7:0];
    else if (wr && wb_adr_i[7:2] == ccr_pkg::REG_PAIR)
    begin
      gpr_q[{bank, wb_dat_i[17:16], 1'b0}] <= wb_dat_i[7:0];
      gpr_q[{bank, wb_dat_i[17:16], 1'b1}] <= wb_dat_i[15:8];
    end
  end

  // Pair view: even byte low, odd byte high.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      pair_q <= 16'h0000;
    else if (rd && wb_adr_i[7:2] == ccr_pkg::REG_PAIR)
      pair_q <= {gpr_q[{bank, wb_dat_i[17:16], 1'b1}],
                 gpr_q[{bank, wb_dat_i[17:16], 1'b0}]};
  end

  // Data memory port: banks answer; peripheral region unassigned.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mem_rdata <= 8'h00;
      mem_hit   <= 1'b0;
    end
    else if (in_range(mem_addr, ccr_pkg::GPR_LO, ccr_pkg::GPR_HI))
    begin
      mem_rdata <= gpr_q[gpr_index(mem_addr)];
      mem_hit   <= 1'b1;
    end
    else if (in_range(mem_addr, ccr_pkg::PERIPH_LO, ccr_pkg::PERIPH_HI))
    begin
      mem_rdata <= ccr_pkg::UNMAPPED_READ;
      mem_hit   <= 1'b0;
    end
    else
    begin
      mem_rdata <= ccr_pkg::UNMAPPED_READ;
      mem_hit   <= 1'b0;
    end
  end

  // Bus read data: unmapped offsets return zero.
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      wb_dat_o <= 32'h0000_0000;
    else if (rd)
    begin
      case (wb_adr_i[7:2])
        ccr_pkg::REG_PC:     wb_dat_o <= {16'h0000, program_counter};
        ccr_pkg::REG_FLAGS:  wb_dat_o <= {24'h00_0000, processor_flags_word};
        ccr_pkg::REG_SP:     wb_dat_o <= {16'h0000, stack_top_pointer};
        ccr_pkg::REG_RESULT: wb_dat_o <= {24'h00_0000, result_q};
        ccr_pkg::REG_IRQ:    wb_dat_o <= {29'h0000_0000, ret_state_q};
        ccr_pkg::REG_STKDAT: wb_dat_o <= {24'h00_0000, stk_dat_q};
        ccr_pkg::REG_PAIR:   wb_dat_o <= {16'h0000, pair_q};
        default:
          if (wb_adr_i[7:5] == ccr_pkg::REG_GPR[5:3])
            wb_dat_o <= {24'h00_0000, gpr_q[{bank, wb_adr_i[4:2]}]};
          else
            wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

endmodule : ccr_core
`default_nettype wire

// >>> sim/ccr_core_props.sv
`timescale 1ns/1ns
`default_nettype none
module ccr_core_props (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic        wb_ack_o,
  input wire logic [15:0] mem_addr,
  input wire logic        mem_we,
  input wire logic [7:0]  mem_wdata,
  input wire logic        mem_hit,
  input wire logic        irq_req,
  input wire logic        irq_unmasked,
  input wire logic        irq_accept,
  input wire logic [15:0] stack_addr,
  input wire logic [15:0] program_counter
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic cw;
  assign cw = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0]
    && wb_adr_i[7:2] == ccr_pkg::REG_CMD;
  ack_latency_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer timing wrong");
  pc_advance_a:
    assert property (cw && wb_dat_i[3:0] == ccr_pkg::CMD_ADVANCE |=> program_counter
      == $past(program_counter) + 16'($past(wb_dat_i[6:4])))
    else $error("program counter did not advance by length");
  pc_branch_a:
    assert property (cw && wb_dat_i[3:0] == ccr_pkg::CMD_BRANCH
      |=> program_counter == $past(wb_dat_i[31:16]))
    else $error("branch target not loaded");
  vector_high_a:
    assert property (mem_we && mem_addr == ccr_pkg::RESET_VEC_HI
      |=> program_counter[15:8] == $past(mem_wdata))
    else $error("vector high byte not from odd address");
  irq_gate_a:
    assert property (irq_accept |-> irq_req && irq_unmasked)
    else $error("interrupt accepted without request");
  gpr_hit_a:
    assert property (1'b1 |=> mem_hit == ($past(mem_addr) >= ccr_pkg::GPR_LO
      && $past(mem_addr) <= ccr_pkg::GPR_HI))
    else $error("register range decode wrong");
  push_predec_a:
    assert property (cw && wb_dat_i[3:0] == ccr_pkg::CMD_PUSH_BYTE
      |=> stack_addr == $past(stack_addr) - 16'h0001)
    else $error("stack pointer not decremented on save");
  unmapped_wr_a:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i
      && wb_adr_i[7:2] == 6'h10
      |=> $stable(program_counter) && $stable(stack_addr))
    else $error("unmapped write changed state");
  cover property (irq_accept);
  cover property (cw);
  cover property (mem_hit);
endmodule : ccr_core_props
bind ccr_core ccr_core_props u_props (.core_clk, .rst_n, .wb_cyc_i, .wb_stb_i,
  .wb_we_i, .wb_adr_i, .wb_dat_i, .wb_sel_i, .wb_ack_o, .mem_addr, .mem_we,
  .mem_wdata, .mem_hit, .irq_req, .irq_unmasked, .irq_accept, .stack_addr,
  .program_counter);
`default_nettype wire

// >>> sim/ccr_core_tb.sv
`timescale 1ns/1ns
`default_nettype none
module ccr_core_tb;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wb_cyc_i = 1'b0;
  logic        wb_stb_i = 1'b0;
  logic        wb_we_i = 1'b0;
  logic [7:0]  wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [3:0]  wb_sel_i = 4'hF;
  logic [31:0] wb_dat_o;
  logic        wb_ack_o;
  logic [15:0] mem_addr = 16'h0000;
  logic        mem_we = 1'b0;
  logic [7:0]  mem_wdata = 8'h00;
  logic [7:0]  mem_rdata;
  logic        mem_hit;
  logic        irq_req = 1'b0;
  logic        irq_low_level = 1'b0;
  logic        irq_unmasked = 1'b0;
  logic        irq_accept;
  logic [15:0] stack_addr;
  logic [15:0] program_counter;
  logic [31:0] rdata;
  int          miscompares = 0;
  int          checked = 0;
  int          cycles = 0;

  ccr_core dut (.core_clk, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_dat_i, .wb_sel_i, .wb_dat_o, .wb_ack_o, .mem_addr, .mem_we, .mem_wdata,
    .mem_rdata, .mem_hit, .irq_req, .irq_low_level, .irq_unmasked, .irq_accept,
    .stack_addr, .program_counter);

  always #4 core_clk = ~core_clk;

  task automatic final_report;
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  always @(posedge core_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 5000)
    begin
      miscompares++;
      final_report();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [5:0] w, input logic [31:0] d);
    @(posedge core_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= {w, 2'b00};
    wb_dat_i <= d;
    do @(posedge core_clk); while (wb_ack_o !== 1'b1);
    rdata = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb

  task automatic cmd(input ccr_pkg::ccr_cmd_t c, input logic [31:0] a);
    wb(1'b1, ccr_pkg::REG_CMD, a | {28'h000_0000, c});
  endtask : cmd

  task automatic memw(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    mem_addr  <= a;
    mem_we    <= 1'b1;
    mem_wdata <= d;
    @(posedge core_clk);
    mem_we    <= 1'b0;
  endtask : memw

  task automatic memr(input logic [15:0] a);
    @(posedge core_clk);
    mem_addr <= a;
    @(posedge core_clk);
    @(negedge core_clk);
  endtask : memr

  initial
  begin
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    wb(1'b0, ccr_pkg::REG_FLAGS, 32'h0000_0000);
    chk(rdata[7:0], 16'h0002);
    memw(16'h0000, 8'h34);
    memw(16'h0001, 8'h12);
    wb(1'b0, ccr_pkg::REG_PC, 32'h0000_0000);
    chk(rdata[15:0], 16'h1234);
    cmd(ccr_pkg::CMD_ADVANCE, 32'h0000_0030);
    cmd(ccr_pkg::CMD_BRANCH, 32'hBEEF_0000);
    wb(1'b0, ccr_pkg::REG_PC, 32'h0000_0000);
    chk(rdata[15:0], 16'hBEEF);
    irq_req <= 1'b1;
    irq_unmasked <= 1'b1;
    cmd(ccr_pkg::CMD_UNMASK_ALL, 32'h0000_0000);
    @(negedge core_clk);
    chk(irq_accept, 1'b1);
    wb(1'b1, ccr_pkg::REG_FLAGS, 32'h0000_0080);
    irq_low_level <= 1'b1;
    @(negedge core_clk);
    chk(irq_accept, 1'b0);
    @(posedge core_clk);
    irq_low_level <= 1'b0;
    cmd(ccr_pkg::CMD_MASK_ALL, 32'h0000_0000);
    @(negedge core_clk);
    chk(irq_accept, 1'b0);
    cmd(ccr_pkg::CMD_UNMASK_ALL, 32'h0000_0000);
    wb(1'b1, ccr_pkg::REG_SP, 32'h0000_FEE0);
    cmd(ccr_pkg::CMD_INTERRUPT, 32'h0100_0000);
    wb(1'b0, ccr_pkg::REG_PC, 32'h0000_0000);
    chk(rdata[15:0], 16'h0100);
    wb(1'b0, ccr_pkg::REG_SP, 32'h0000_0000);
    chk(rdata[15:0], 16'hFEDD);
    wb(1'b0, ccr_pkg::REG_FLAGS, 32'h0000_0000);
    chk(rdata[7], 1'b0);
    cmd(ccr_pkg::CMD_PUSH_FLAGS, 32'h0000_0000);
    wb(1'b0, ccr_pkg::REG_SP, 32'h0000_0000);
    chk(rdata[15:0], 16'hFEDC);
    cmd(ccr_pkg::CMD_PUSH_BYTE, 32'h0000_0000);
    cmd(ccr_pkg::CMD_POP_BYTE, 32'h0000_0000);
    wb(1'b0, ccr_pkg::REG_SP, 32'h0000_0000);
    chk(rdata[15:0], 16'hFEDC);
    cmd(ccr_pkg::CMD_INT_RETURN, 32'h0000_0000);
    repeat (6) @(posedge core_clk);
    wb(1'b0, ccr_pkg::REG_SP, 32'h0000_0000);
    chk(rdata[15:0], 16'hFEDF);
    wb(1'b1, ccr_pkg::REG_STKDAT, 32'h0000_0042);
    cmd(ccr_pkg::CMD_POP_FLAGS, 32'h0000_0000);
    wb(1'b0, ccr_pkg::REG_FLAGS, 32'h0000_0000);
    chk(rdata[7:0], 16'h0042);
    wb(1'b0, ccr_pkg::REG_SP, 32'h0000_0000);
    chk(rdata[15:0], 16'hFEE0);
    cmd(ccr_pkg::CMD_ALU_ADD, 32'h0008_0800);
    wb(1'b0, ccr_pkg::REG_FLAGS, 32'h0000_0000);
    chk(rdata[7:0] & 8'h51, 16'h0010);
    cmd(ccr_pkg::CMD_ALU_ADD, 32'h0080_8000);
    wb(1'b0, ccr_pkg::REG_FLAGS, 32'h0000_0000);
    chk(rdata[7:0] & 8'h51, 16'h0041);
    cmd(ccr_pkg::CMD_ALU_SUB, 32'h0001_1000);
    wb(1'b0, ccr_pkg::REG_FLAGS, 32'h0000_0000);
    chk(rdata[7:0] & 8'h51, 16'h0010);
    cmd(ccr_pkg::CMD_ROTATE, 32'h0000_8000);
    wb(1'b0, ccr_pkg::REG_FLAGS, 32'h0000_0000);
    chk(rdata[0], 1'b1);
    wb(1'b0, ccr_pkg::REG_RESULT, 32'h0000_0000);
    chk(rdata[7:0], 16'h0001);
    for (int b = 0; b < 4; b++)
    begin
      memw(16'hFEF8 - 16'(8 * b), 8'hA0 + 8'(b));
      cmd(ccr_pkg::CMD_BANK_SWITCH, 32'(b) << 4);
      wb(1'b0, ccr_pkg::REG_GPR, 32'h0000_0000);
      chk(rdata[7:0], 16'(8'hA0 + 8'(b)));
      wb(1'b0, ccr_pkg::REG_FLAGS, 32'h0000_0000);
      chk({rdata[5], rdata[3]}, 16'(b));
    end
    wb(1'b1, ccr_pkg::REG_PAIR, 32'h0001_BBAA);
    memr(16'hFEE3);
    chk(mem_rdata, 16'h00BB);
    chk(mem_hit, 1'b1);
    cmd(ccr_pkg::CMD_BRK_RETURN, 32'h0000_0000);
    repeat (6) @(posedge core_clk);
    wb(1'b0, ccr_pkg::REG_PC, 32'h0000_0000);
    chk(rdata[15:0], 16'hBBBB);
    wb(1'b0, ccr_pkg::REG_FLAGS, 32'h0000_0000);
    chk(rdata[7:0], 16'h00BB);
    memr(16'hFF00);
    chk(mem_hit, 1'b0);
    wb(1'b1, 6'h10, 32'hFFFF_FFFF);
    wb(1'b0, 6'h10, 32'h0000_0000);
    chk(rdata[15:0], 16'h0000);
    final_report();
  end
endmodule : ccr_core_tb
`default_nettype wire
